// *** common/sfsr_pkg.sv ***
// Constants and types for the supply fault status register block.
// Assumes a single clock domain and a plain address/strobe register port.
package sfsr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int SFSR_ADDR_W = 8;
  localparam int SFSR_DATA_W = 16;
  localparam logic [SFSR_ADDR_W-1:0] SUPPLY_FAULT_FLAGS_OFFSET = 8'h0e;
  localparam logic [SFSR_DATA_W-1:0] SUPPLY_FAULT_FLAGS_RESET = 16'h0000;

  // ==========================================================================
  // Field layout: source k owns flag bit 2k+1 and clear bit 2k
  // ==========================================================================
  localparam int NUM_SOURCES = 8;
  localparam int CHECKSUM_ERROR_FLAG_BIT = 15;
  localparam int CHECKSUM_ERROR_CLEAR_BIT = 14;
  localparam int BOOST_SYNC_MISSING_FLAG_BIT = 13;
  localparam int BOOST_SYNC_MISSING_CLEAR_BIT = 12;
  localparam int CHARGE_PUMP_FAULT_FLAG_BIT = 11;
  localparam int CHARGE_PUMP_FAULT_CLEAR_BIT = 10;
  localparam int PUMP_CAPACITOR_MISSING_FLAG_BIT = 9;
  localparam int PUMP_CAPACITOR_MISSING_CLEAR_BIT = 8;
  localparam int INPUT_OVERCURRENT_FLAG_BIT = 7;
  localparam int INPUT_OVERCURRENT_CLEAR_BIT = 6;
  localparam int INTERNAL_SUPPLY_UNDERVOLT_FLAG_BIT = 5;
  localparam int INTERNAL_SUPPLY_UNDERVOLT_CLEAR_BIT = 4;
  localparam int INPUT_OVERVOLT_FLAG_BIT = 3;
  localparam int INPUT_OVERVOLT_CLEAR_BIT = 2;
  localparam int INPUT_UNDERVOLT_FLAG_BIT = 1;
  localparam int INPUT_UNDERVOLT_CLEAR_BIT = 0;
  localparam logic [NUM_SOURCES-1:0] FAULTS_NONE = 8'h00;

  // ==========================================================================
  // Fault sources, bit k of the vector is source k
  // ==========================================================================
  typedef struct packed {
    logic checksumError;
    logic boostSyncMissing;
    logic chargePumpFault;
    logic pumpCapacitorMissing;
    logic inputOvercurrent;
    logic internalSupplyUndervolt;
    logic inputOvervolt;
    logic inputUndervolt;
  } sfsr_faults_t;

endpackage

// *** design/sfsr_supply_fault_status.sv ***
// Supply fault status register: eight sticky fault flags with paired clears.
// Assumes fault detector levels arrive asynchronously and a host register
// port that never needs wait states.
//
// Summary of operation
// - Checksum flag sets on fault, reads zero otherwise
// - Checksum flag has companion clear bit
// - Write flag and clear together to clear
// - Clear removes flag and its interrupt contribution
// - Boost sync missing flag with paired clear
// - Charge pump flag, clear at bit 10
// - Capacitor missing flag bit 9, clear 8
// - Input overcurrent flag bit 7, clear 6
// - Internal undervolt flag bit 5, clear 4
// - Input overvolt flag bit 3, clear 2
// - Input undervolt flag bit 1, clear 0
// - Register at offset 0x0e, resets to zero
`timescale 1ns/10ps

module sfsr_supply_fault_status #(
  parameter int ADDR_W = sfsr_pkg::SFSR_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [sfsr_pkg::SFSR_DATA_W-1:0] regWdata,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [sfsr_pkg::SFSR_DATA_W-1:0] regRdata,
  // Fault detector levels, asynchronous
  input wire sfsr_pkg::sfsr_faults_t faultLevel,
  // Latched faults and interrupt contribution
  output sfsr_pkg::sfsr_faults_t faultFlags,
  output logic supplyFaultIrq
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (ADDR_W < 4 || ADDR_W > sfsr_pkg::SFSR_ADDR_W) begin : gBadAddrW
    $error("ADDR_W must lie between 4 and 8");
  end
  if (2 * sfsr_pkg::NUM_SOURCES != sfsr_pkg::SFSR_DATA_W) begin : gBadPairs
    $error("each source needs one flag bit and one clear bit");
  end
  if ((sfsr_pkg::SUPPLY_FAULT_FLAGS_OFFSET >> ADDR_W) != 0) begin : gBadOffset
    $error("register offset does not fit the address width");
  end

  // ==========================================================================
  // Fault input synchronisers
  // ==========================================================================
  // Detector levels are analog-derived and unrelated to core_clk
  logic [sfsr_pkg::NUM_SOURCES-1:0] faultMeta_reg;
  logic [sfsr_pkg::NUM_SOURCES-1:0] faultSync_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      faultMeta_reg <= sfsr_pkg::FAULTS_NONE;
      faultSync_reg <= sfsr_pkg::FAULTS_NONE;
    end else begin
      faultMeta_reg <= faultLevel;
      faultSync_reg <= faultMeta_reg;
    end
  end

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire logic [sfsr_pkg::SFSR_ADDR_W-1:0] addrFull;
  wire logic addrHit;
  wire logic regWrite;
  wire logic regRead;

  assign addrFull = sfsr_pkg::SFSR_ADDR_W'(regAddr);
  assign addrHit = (addrFull == sfsr_pkg::SUPPLY_FAULT_FLAGS_OFFSET);
  assign regWrite = regWrStrobe & addrHit;
  assign regRead = regRdStrobe & addrHit;

  // ==========================================================================
  // Sticky flags
  // ==========================================================================
  logic [sfsr_pkg::NUM_SOURCES-1:0] flag_reg;
  logic [sfsr_pkg::NUM_SOURCES-1:0] flag_next;
  wire logic [sfsr_pkg::NUM_SOURCES-1:0] wrFlagBits;
  wire logic [sfsr_pkg::NUM_SOURCES-1:0] wrClearBits;
  wire logic [sfsr_pkg::NUM_SOURCES-1:0] clearHit;
  wire logic [sfsr_pkg::SFSR_DATA_W-1:0] readWord;

  for (genvar k = 0; k < sfsr_pkg::NUM_SOURCES; k++) begin : gPair
    // Pair k: flag at 2k+1, clear at 2k; clears never read back
    assign wrFlagBits[k] = regWdata[2*k+1];
    assign wrClearBits[k] = regWdata[2*k];
    assign readWord[2*k+1] = flag_reg[k];
    assign readWord[2*k] = 1'b0;
  end

  // Both bits must be one in a single write
  assign clearHit = {sfsr_pkg::NUM_SOURCES{regWrite}} & wrFlagBits & wrClearBits;
  // A fault still present wins over a clear in the same cycle
  assign flag_next = faultSync_reg | (flag_reg & ~clearHit);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag_reg <= sfsr_pkg::SUPPLY_FAULT_FLAGS_RESET[sfsr_pkg::NUM_SOURCES-1:0];
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign faultFlags = flag_reg;
  // Only the latched flags feed the pin, so clearing the last latched flag drops it too
  assign supplyFaultIrq = |flag_reg;

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Unmapped reads and idle cycles return zero
  logic [sfsr_pkg::SFSR_DATA_W-1:0] rdata_reg;
  wire logic [sfsr_pkg::SFSR_DATA_W-1:0] rdata_next;

  assign rdata_next = regRead ? readWord : sfsr_pkg::SUPPLY_FAULT_FLAGS_RESET;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_reg <= sfsr_pkg::SUPPLY_FAULT_FLAGS_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

  // ==========================================================================
  // Assertion arming
  // ==========================================================================
  // Checks skip the release edge, so history from before reset is never used
  logic asrtArmed_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      asrtArmed_reg <= 1'b0;
    end else begin
      asrtArmed_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cbAsrt @(posedge core_clk);
  endclocking
  default disable iff (!reset_n || !asrtArmed_reg);

  sequence seqPairedClearAll;
    regWrStrobe && addrHit && (regWdata == 16'hffff);
  endsequence

  sequence seqNoFaultsQuiet;
    (faultLevel == sfsr_pkg::FAULTS_NONE)[*3];
  endsequence

  sequence seqReadMapped;
    regRdStrobe && addrHit;
  endsequence

  // Reset leaves everything at zero after the first released edge
  chk_reset_clears_all: assert property (
    disable iff (1'b0)
    !reset_n |=> (flag_reg == sfsr_pkg::FAULTS_NONE) && (regRdata == 16'h0000)
  ) else $error("flags or read data not zero after reset");

  // Clear bits are always zero on the read port
  chk_clear_bits_zero: assert property (
    (regRdata & 16'h5555) == 16'h0000
  ) else $error("clear bit read back as one");

  // Mapped read returns the flags as they stood at the strobe
  chk_read_returns_flags: assert property (
    seqReadMapped |=> regRdata == {
      $past(flag_reg[7]), 1'b0, $past(flag_reg[6]), 1'b0,
      $past(flag_reg[5]), 1'b0, $past(flag_reg[4]), 1'b0,
      $past(flag_reg[3]), 1'b0, $past(flag_reg[2]), 1'b0,
      $past(flag_reg[1]), 1'b0, $past(flag_reg[0]), 1'b0}
  ) else $error("read data does not match latched flags");

  // Read data stands only in the cycle after a mapped read
  chk_read_only_after: assert property (
    !(regRdStrobe && addrHit) |=> regRdata == 16'h0000
  ) else $error("read data nonzero without mapped read");

  // Interrupt contribution is exactly the OR of the latched flags
  chk_irq_follows_flags: assert property (
    supplyFaultIrq == (faultFlags != sfsr_pkg::FAULTS_NONE)
  ) else $error("interrupt output disagrees with flags");

  // With all detectors quiet, a full paired clear drops the pin
  chk_clear_drops_irq: assert property (
    seqNoFaultsQuiet ##0 seqPairedClearAll |=> !supplyFaultIrq && (faultFlags == 8'h00)
  ) else $error("paired clear left interrupt asserted");

  // A write touching only flag bits never clears anything
  chk_flag_only_write: assert property (
    regWrStrobe && ((regWdata & 16'h5555) == 16'h0000) |=> $past(flag_reg) == (flag_reg & $past(flag_reg))
  ) else $error("flag-only write cleared a fault");

  // A write touching only clear bits never clears anything
  chk_clear_only_write: assert property (
    regWrStrobe && ((regWdata & 16'haaaa) == 16'h0000) |=> $past(flag_reg) == (flag_reg & $past(flag_reg))
  ) else $error("clear-only write cleared a fault");

  // Writes to other addresses never clear
  chk_unmapped_write: assert property (
    regWrStrobe && !addrHit |=> (flag_reg & $past(flag_reg)) == $past(flag_reg)
  ) else $error("unmapped write changed flags");

  // Write strobe low means flags can only gain bits
  chk_flags_sticky: assert property (
    !regWrStrobe |=> (flag_reg & $past(flag_reg)) == $past(flag_reg)
  ) else $error("latched flag dropped without a write");

  for (genvar k = 0; k < sfsr_pkg::NUM_SOURCES; k++) begin : gChk
    // Fault level seen at the pin is latched three edges later
    chk_fault_latches: assert property (
      faultLevel[k] |-> ##3 flag_reg[k]
    ) else $error("fault level not latched in three cycles");

    // Flag rises only after the detector was high three edges before
    chk_flag_has_cause: assert property (
      $rose(flag_reg[k]) |-> $past(faultLevel[k], 3)
    ) else $error("flag rose without a fault");

    // Paired write with no pending fault clears in one cycle
    chk_paired_clears: assert property (
      regWrStrobe && addrHit && regWdata[2*k+1] && regWdata[2*k] && !faultSync_reg[k]
      |=> !flag_reg[k]
    ) else $error("paired write did not clear the flag");

    // Fault still present beats the clear
    chk_set_beats_clear: assert property (
      regWrStrobe && faultSync_reg[k] |=> flag_reg[k]
    ) else $error("clear won over a pending fault");

    // Flag that falls was cleared by its pair
    chk_fall_has_clear: assert property (
      $fell(flag_reg[k]) |-> $past(regWrStrobe && addrHit && regWdata[2*k+1] && regWdata[2*k])
    ) else $error("flag fell without a paired write");

    // One bit of the pair alone never clears the flag
    chk_half_pair_keeps: assert property (
      regWrite && (regWdata[2*k+1] ^ regWdata[2*k])
      |=> flag_reg[k] == $past(flag_reg[k] | faultSync_reg[k])
    ) else $error("half of a pair changed the flag");

    // Latched flag holds while no write reaches the register
    chk_flag_holds: assert property (
      flag_reg[k] && !regWrite |=> flag_reg[k]
    ) else $error("latched flag dropped without a write");

    // Synchronised level latches on the next edge
    chk_sync_sets_flag: assert property (
      faultSync_reg[k] |=> flag_reg[k]
    ) else $error("synchronised fault not latched");
  end

  // Pin stays low while detectors, synchroniser and flags are all quiet
  chk_quiet_irq_low: assert property (
    ((flag_reg == 8'h00) && (faultSync_reg == 8'h00) &&
      ($past(faultLevel) == sfsr_pkg::FAULTS_NONE)) ##0 seqNoFaultsQuiet
      |-> ##1 (flag_reg == 8'h00) ##1 !supplyFaultIrq
  ) else $error("interrupt rose with all detectors quiet");

  // Pump capacitor flag is bit 9, charge pump clear bit 10 reads zero
  chk_field_positions: assert property (
    seqReadMapped |=> regRdata[9] == $past(flag_reg[4]) && !regRdata[10] && !regRdata[8]
  ) else $error("field positions wrong on read");

  // Checksum flag at bit 15, its clear at bit 14 reads zero
  chk_checksum_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::CHECKSUM_ERROR_FLAG_BIT] ==
        $past(faultFlags.checksumError)) &&
      !regRdata[sfsr_pkg::CHECKSUM_ERROR_CLEAR_BIT]
  ) else $error("checksum flag not at its field");

  // Boost sync flag at bit 13, clear at bit 12
  chk_boost_sync_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::BOOST_SYNC_MISSING_FLAG_BIT] ==
        $past(faultFlags.boostSyncMissing)) &&
      !regRdata[sfsr_pkg::BOOST_SYNC_MISSING_CLEAR_BIT]
  ) else $error("boost sync flag not at its field");

  // Charge pump flag at bit 11, clear at bit 10
  chk_pump_fault_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::CHARGE_PUMP_FAULT_FLAG_BIT] ==
        $past(faultFlags.chargePumpFault)) &&
      !regRdata[sfsr_pkg::CHARGE_PUMP_FAULT_CLEAR_BIT]
  ) else $error("charge pump flag not at its field");

  // Capacitor flag at bit 9, clear at bit 8
  chk_capacitor_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::PUMP_CAPACITOR_MISSING_FLAG_BIT] ==
        $past(faultFlags.pumpCapacitorMissing)) &&
      !regRdata[sfsr_pkg::PUMP_CAPACITOR_MISSING_CLEAR_BIT]
  ) else $error("capacitor flag not at its field");

  // Input overcurrent flag at bit 7, clear at bit 6
  chk_overcurrent_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::INPUT_OVERCURRENT_FLAG_BIT] ==
        $past(faultFlags.inputOvercurrent)) &&
      !regRdata[sfsr_pkg::INPUT_OVERCURRENT_CLEAR_BIT]
  ) else $error("overcurrent flag not at its field");

  // Internal undervolt flag at bit 5, clear at bit 4
  chk_supply_uv_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::INTERNAL_SUPPLY_UNDERVOLT_FLAG_BIT] ==
        $past(faultFlags.internalSupplyUndervolt)) &&
      !regRdata[sfsr_pkg::INTERNAL_SUPPLY_UNDERVOLT_CLEAR_BIT]
  ) else $error("internal undervolt flag not at its field");

  // Input overvolt flag at bit 3, clear at bit 2
  chk_overvolt_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::INPUT_OVERVOLT_FLAG_BIT] ==
        $past(faultFlags.inputOvervolt)) &&
      !regRdata[sfsr_pkg::INPUT_OVERVOLT_CLEAR_BIT]
  ) else $error("overvolt flag not at its field");

  // Input undervolt flag at bit 1, clear at bit 0
  chk_undervolt_field: assert property (
    seqReadMapped |=>
      (regRdata[sfsr_pkg::INPUT_UNDERVOLT_FLAG_BIT] ==
        $past(faultFlags.inputUndervolt)) &&
      !regRdata[sfsr_pkg::INPUT_UNDERVOLT_CLEAR_BIT]
  ) else $error("undervolt flag not at its field");

  // Pin rises only while a synchronised fault is latching
  chk_irq_rise_cause: assert property (
    $rose(supplyFaultIrq) |-> $past(faultSync_reg != sfsr_pkg::FAULTS_NONE)
  ) else $error("interrupt rose without a fault");

  // Pin falls only after a mapped write
  chk_irq_fall_cause: assert property (
    $fell(supplyFaultIrq) |-> $past(regWrite)
  ) else $error("interrupt fell without a register write");

endmodule

// *** bench/sfsr_host_model.sv ***
// Host controller model: drives the plain register port of the fault register.
// Assumes one clock; the caller sequences the transfers.
`timescale 1ns/10ps

module sfsr_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [7:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWrStrobe,
  output logic regRdStrobe,
  input wire logic [15:0] regRdata
);
  // ==========================================================================
  // Idle values
  // ==========================================================================
  initial begin
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
  end

  // ==========================================================================
  // Transfers
  // ==========================================================================
  // Flag and clear bits of one source go in the same write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrStrobe <= 1'b1;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
    regWdata <= ~d;
  endtask

  // Data taken only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule

// *** bench/supply_fault_status_register_tb_top.sv ***
// Testbench for the supply fault status register, with an integer model.
// Assumes the host model drives the register port.
`timescale 1ns/10ps

module supply_fault_status_register_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr;
  logic [15:0] regWdata;
  logic regWrStrobe;
  logic regRdStrobe;
  logic [15:0] regRdata;
  sfsr_pkg::sfsr_faults_t faultLevel = 8'h00;
  sfsr_pkg::sfsr_faults_t faultFlags;
  logic supplyFaultIrq;
  int errCount = 0;
  int compares = 0;
  int mdl = 0;
  logic [15:0] rdv;
  logic [15:0] expQ[$];
  localparam logic [7:0] OFF = sfsr_pkg::SUPPLY_FAULT_FLAGS_OFFSET;

  always #2 core_clk = ~core_clk;

  sfsr_supply_fault_status u_sfsr_supply_fault_status (.core_clk(core_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdata(regRdata), .faultLevel(faultLevel),
    .faultFlags(faultFlags), .supplyFaultIrq(supplyFaultIrq));

  sfsr_host_model u_sfsr_host_model (.core_clk(core_clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdata(regRdata));

  // ==========================================================================
  // Checking and model
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] spread(input int m);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 8; k++) r[2*k+1] = m[k];
    return r;
  endfunction

  // Pulse gone before the host acts: flags must stay latched
  task automatic raise(input logic [7:0] f);
    @(posedge core_clk);
    faultLevel <= f;
    repeat (3) @(posedge core_clk);
    faultLevel <= 8'h00;
    repeat (3) @(posedge core_clk);
    mdl = mdl | f;
  endtask

  task automatic wr_model(input logic [7:0] a, input logic [15:0] d);
    u_sfsr_host_model.wr(a, d);
    if (a == OFF) begin
      for (int k = 0; k < 8; k++) if (d[2*k+1] && d[2*k]) mdl[k] = 0;
    end
  endtask

  task automatic verify;
    expQ.push_back(spread(mdl));
    u_sfsr_host_model.rd(OFF, rdv);
    check(rdv, expQ.pop_front());
    check({8'h00, faultFlags}, {8'h00, mdl[7:0]});
    check({15'h0000, supplyFaultIrq}, {15'h0000, mdl != 0});
  endtask

  task automatic finalReport;
    $display("Comparisons %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    #100000;
    errCount++;
    finalReport();
  end

  initial begin
    void'($urandom(65));
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    verify();
    for (int k = 0; k < 8; k++) begin
      raise(8'h01 << k);
      verify();
      wr_model(OFF, 16'h0001 << (2*k+1));
      verify();
      wr_model(OFF, 16'h0001 << (2*k));
      verify();
      wr_model(8'h10, 16'h0003 << (2*k));
      u_sfsr_host_model.rd(8'h10, rdv);
      check(rdv, 16'h0000);
      verify();
      wr_model(OFF, 16'h0003 << (2*k));
      verify();
    end
    // Mixed sources and writes, some to a neighbouring address
    for (int i = 0; i < 40; i++) begin
      raise(8'($urandom));
      wr_model(($urandom % 2) ? OFF : 8'h0c, 16'($urandom));
      verify();
    end
    // Full paired clear with every detector quiet
    raise(8'hff);
    wr_model(OFF, 16'hffff);
    verify();
    // Fault still present at the clear keeps its flag
    @(posedge core_clk);
    faultLevel <= 8'h81;
    repeat (3) @(posedge core_clk);
    mdl = mdl | 8'h81;
    u_sfsr_host_model.wr(OFF, 16'hc003);
    verify();
    @(posedge core_clk);
    faultLevel <= 8'h00;
    repeat (3) @(posedge core_clk);
    wr_model(OFF, 16'hc003);
    verify();
    // Reset in mid-run drops every latched flag
    raise(8'hff);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    mdl = 0;
    verify();
    finalReport();
  end
endmodule
